// file: qctu_consts.svh
// constants for the quad counter/timer unit: addresses, field positions, resets, divider counts
`ifndef QCTU_CONSTS_SVH
`define QCTU_CONSTS_SVH
`define QCTU_ADDR_T2_RELOAD_LOW 8'hCA
`define QCTU_ADDR_T2_RELOAD_HIGH 8'hCB
`define QCTU_RELOAD_RESET 8'h00
`define QCTU_COUNT_RESET 8'h00
`define QCTU_CTRL_SPLIT_BIT 3
`define QCTU_CTRL_RUN_BIT 2
`define QCTU_CTRL_LOW_IRQ_EN_BIT 5
`define QCTU_CTRL_HIGH_FLAG_BIT 7
`define QCTU_DIV4_LAST 2'h3
`define QCTU_DIV12_LAST 4'hB
`define QCTU_DIV48_LAST 2'h3
`endif

// file: qctu_pkg.sv
// types shared by the quad counter/timer unit
package qctu_pkg;
    // timer 0/1 operating modes
    typedef enum logic [1:0] {
        QCTU_MODE_13BIT,
        QCTU_MODE_16BIT,
        QCTU_MODE_8BIT_RELOAD,
        QCTU_MODE_SPLIT
    } qctu_mode_t;
    // shared prescaler choice for timers 0/1
    typedef enum logic [1:0] {
        QCTU_SCALE_DIV12,
        QCTU_SCALE_DIV4,
        QCTU_SCALE_DIV48,
        QCTU_SCALE_EXT8
    } qctu_scale_t;
endpackage

// file: qctu_reload_timer.sv
// 16-bit / split 8-bit auto-reload timer used for timers 2 and 3
`include "qctu_consts.svh"
module qctu_reload_timer (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // configuration
    input wire logic split,
    input wire logic run,
    input wire logic low_clock_pick,
    input wire logic high_clock_pick,
    input wire logic alt_tick,
    input wire logic [7:0] reload_low,
    input wire logic [7:0] reload_high,
    input wire logic irq_enable,
    input wire logic low_irq_enable,
    // flag clears (software writes zero)
    input wire logic clr_high_flag,
    input wire logic clr_low_flag,
    // state
    output logic [7:0] count_low,
    output logic [7:0] count_high,
    output logic high_flag,
    output logic low_flag,
    output logic irq
);
    logic [7:0] count_low_ff; // low byte
    logic [7:0] count_high_ff; // high byte
    logic high_flag_ff; // high byte overflow flag
    logic low_flag_ff; // low byte overflow flag
    logic tick_low; // low half advance
    logic tick_high; // high half advance
    logic ev_low; // low byte wraps this cycle
    logic ev_high; // high byte wraps this cycle

    // clock pick: set means system clock, else the alternate clock
    assign tick_low = low_clock_pick ? 1'b1 : alt_tick;
    assign tick_high = high_clock_pick ? 1'b1 : alt_tick;

    // overflow events for both modes
    always_comb begin
        if (split) begin
            ev_low = tick_low && (count_low_ff == 8'hFF);
            ev_high = run && tick_high && (count_high_ff == 8'hFF);
        end else begin
            ev_low = run && tick_low && (count_low_ff == 8'hFF);
            ev_high = ev_low && (count_high_ff == 8'hFF);
        end
    end

    // count registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_low_ff <= `QCTU_COUNT_RESET;
            count_high_ff <= `QCTU_COUNT_RESET;
        end else if (split) begin
            // low half free-runs, high half gated by run
            if (tick_low) begin
                count_low_ff <= ev_low ? reload_low : count_low_ff + 8'h01;
            end
            if (run && tick_high) begin
                count_high_ff <= ev_high ? reload_high : count_high_ff + 8'h01;
            end
        end else if (run && tick_low) begin
            // 16-bit wrap loads the full reload value
            if (ev_high) begin
                count_low_ff <= reload_low;
                count_high_ff <= reload_high;
            end else begin
                count_low_ff <= count_low_ff + 8'h01;
                if (ev_low) begin
                    count_high_ff <= count_high_ff + 8'h01;
                end
            end
        end
    end

    // sticky flags, set beats clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            high_flag_ff <= 1'b0;
            low_flag_ff <= 1'b0;
        end else begin
            if (ev_high) begin
                high_flag_ff <= 1'b1;
            end else if (clr_high_flag) begin
                high_flag_ff <= 1'b0;
            end
            if (ev_low) begin
                low_flag_ff <= 1'b1;
            end else if (clr_low_flag) begin
                low_flag_ff <= 1'b0;
            end
        end
    end

    // interrupt request from the flags
    assign irq = irq_enable && (high_flag_ff || (low_irq_enable && low_flag_ff));
    assign count_low = count_low_ff;
    assign count_high = count_high_ff;
    assign high_flag = high_flag_ff;
    assign low_flag = low_flag_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_reload16;
        !split && run && tick_low && count_low == 8'hFF && count_high == 8'hFF
            |=> count_low == $past(reload_low) && count_high == $past(reload_high);
    endproperty
    a_reload16: assert property (p_reload16) else $error("16-bit reload missed");
    property p_high_flag;
        ev_high |=> high_flag ##1 (high_flag || $past(clr_high_flag));
    endproperty
    a_high_flag: assert property (p_high_flag) else $error("high flag not held");
    property p_irq_high;
        irq_enable && high_flag |-> irq;
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("overflow irq missing");
    property p_irq_low;
        irq_enable && low_irq_enable && low_flag |-> irq;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("low byte irq missing");
    property p_split_low_runs;
        split && $past(split) && !run && tick_low && count_low != 8'hFF
            |=> count_low == $past(count_low) + 8'h01;
    endproperty
    a_split_low_runs: assert property (p_split_low_runs) else $error("low half stalled");
    property p_split_high_hold;
        split && !run |=> count_high == $past(count_high);
    endproperty
    a_split_high_hold: assert property (p_split_high_hold) else $error("high half ran");
    property p_split_reload;
        split && tick_low && count_low == 8'hFF |=> count_low == $past(reload_low);
    endproperty
    a_split_reload: assert property (p_split_reload) else $error("low reload missed");
    property p_sticky;
        high_flag && !clr_high_flag |=> high_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped alone");
    c_wrap16: cover property (!split && ev_high);
    c_split_low: cover property (split && ev_low);
endmodule // qctu_reload_timer

// file: qctu_top.sv
// quad counter/timer unit: timers 0/1 classic modes, timers 2/3 auto-reload
`include "qctu_consts.svh"
module qctu_top (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // special-function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // pins from outside the clock domain
    input wire logic timer0_event_pin,
    input wire logic timer1_event_pin,
    input wire logic ext_osc_div8,
    // timer 0/1 configuration
    input wire qctu_pkg::qctu_mode_t timer0_mode,
    input wire qctu_pkg::qctu_mode_t timer1_mode,
    input wire logic timer0_run,
    input wire logic timer1_run,
    input wire logic timer0_counter_sel,
    input wire logic timer1_counter_sel,
    input wire logic timer0_clock_pick,
    input wire logic timer1_clock_pick,
    input wire logic prescale_field_hi,
    input wire logic prescale_field_lo,
    input wire logic timer0_flag_clr,
    input wire logic timer1_flag_clr,
    // timer 2 configuration
    input wire logic timer2_split_select,
    input wire logic timer2_run,
    input wire logic timer2_ext_clock_select,
    input wire logic timer2_low_clock_pick,
    input wire logic timer2_high_clock_pick,
    input wire logic timer2_irq_enable,
    input wire logic timer2_low_irq_enable,
    input wire logic timer2_high_flag_clr,
    input wire logic timer2_low_flag_clr,
    // timer 3 configuration
    input wire logic [7:0] timer3_control,
    input wire logic [7:0] timer3_reload_low,
    input wire logic [7:0] timer3_reload_high,
    input wire logic timer3_ext_clock_select,
    input wire logic timer3_low_clock_pick,
    input wire logic timer3_high_clock_pick,
    input wire logic timer3_irq_enable,
    input wire logic timer3_high_flag_clr,
    input wire logic timer3_low_flag_clr,
    // timer 0/1 state
    output logic [7:0] timer0_count_low,
    output logic [7:0] timer0_count_high,
    output logic [7:0] timer1_count_low,
    output logic [7:0] timer1_count_high,
    output logic timer0_flag,
    output logic timer1_flag,
    // timer 2/3 state
    output logic [7:0] timer2_count_low,
    output logic [7:0] timer2_count_high,
    output logic [7:0] timer3_count_low,
    output logic [7:0] timer3_count_high,
    output logic [3:0] timer23_flags,
    output logic timer2_irq,
    output logic timer3_irq
);
    logic [7:0] t2_reload_low_ff; // timer 2 reload low byte
    logic [7:0] t2_reload_high_ff; // timer 2 reload high byte
    logic [7:0] sfr_rdata_ff; // registered read data
    logic [2:0] ev0_sync_ff; // event pin 0 sync + history
    logic [2:0] ev1_sync_ff; // event pin 1 sync + history
    logic [2:0] ext_sync_ff; // external clock sync + history
    logic [1:0] div4_ff; // divide by 4 counter
    logic [3:0] div12_ff; // divide by 12 counter
    logic [1:0] div48_ff; // counts /12 ticks for /48
    logic [7:0] tl0_ff, th0_ff, tl1_ff, th1_ff; // timer 0/1 counts
    logic tf0_ff, tf1_ff; // timer 0/1 overflow flags
    logic tick4, tick12, tick48, ext_tick, pre_tick; // clock enables
    logic ev0_fall, ev1_fall; // falling edges on event pins
    logic tk0, tk1, tk0h; // timer 0, timer 1, split high byte advance
    logic ov0, ov1, ov0h; // overflow events
    qctu_pkg::qctu_scale_t scale; // prescaler selection

    // overflow decode for the timer 0/1 modes
    function automatic logic ov_hit(qctu_pkg::qctu_mode_t m, logic [7:0] th, logic [7:0] tl);
        case (m)
            qctu_pkg::QCTU_MODE_13BIT: ov_hit = (th == 8'hFF) && (tl[4:0] == 5'h1F);
            qctu_pkg::QCTU_MODE_16BIT: ov_hit = (th == 8'hFF) && (tl == 8'hFF);
            default: ov_hit = (tl == 8'hFF);
        endcase
    endfunction

    // timer 2 reload registers written over the sfr port
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            t2_reload_low_ff <= `QCTU_RELOAD_RESET;
            t2_reload_high_ff <= `QCTU_RELOAD_RESET;
        end else if (sfr_wr) begin
            if (sfr_addr == `QCTU_ADDR_T2_RELOAD_LOW) begin
                t2_reload_low_ff <= sfr_wdata;
            end
            if (sfr_addr == `QCTU_ADDR_T2_RELOAD_HIGH) begin
                t2_reload_high_ff <= sfr_wdata;
            end
        end
    end

    // read data, unmapped addresses read zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata_ff <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                `QCTU_ADDR_T2_RELOAD_LOW: sfr_rdata_ff <= t2_reload_low_ff;
                `QCTU_ADDR_T2_RELOAD_HIGH: sfr_rdata_ff <= t2_reload_high_ff;
                default: sfr_rdata_ff <= 8'h00;
            endcase
        end
    end
    assign sfr_rdata = sfr_rdata_ff;

    // two-flop synchronisers, third flop only for edge detection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ev0_sync_ff <= 3'h7;
            ev1_sync_ff <= 3'h7;
            ext_sync_ff <= 3'h0;
        end else begin
            ev0_sync_ff <= {ev0_sync_ff[1:0], timer0_event_pin};
            ev1_sync_ff <= {ev1_sync_ff[1:0], timer1_event_pin};
            ext_sync_ff <= {ext_sync_ff[1:0], ext_osc_div8};
        end
    end
    // edges seen only from synchronised stages; needs held levels
    assign ev0_fall = ev0_sync_ff[2] && !ev0_sync_ff[1];
    assign ev1_fall = ev1_sync_ff[2] && !ev1_sync_ff[1];
    assign ext_tick = ext_sync_ff[1] && !ext_sync_ff[2];

    // system clock dividers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div4_ff <= 2'h0;
            div12_ff <= 4'h0;
            div48_ff <= 2'h0;
        end else begin
            div4_ff <= div4_ff + 2'h1;
            div12_ff <= tick12 ? 4'h0 : div12_ff + 4'h1;
            if (tick12) begin
                div48_ff <= div48_ff + 2'h1;
            end
        end
    end
    assign tick4 = (div4_ff == `QCTU_DIV4_LAST);
    assign tick12 = (div12_ff == `QCTU_DIV12_LAST);
    assign tick48 = tick12 && (div48_ff == `QCTU_DIV48_LAST);

    // prescaled clock for timers 0/1
    assign scale = qctu_pkg::qctu_scale_t'({prescale_field_hi, prescale_field_lo});
    always_comb begin
        case (scale)
            qctu_pkg::QCTU_SCALE_DIV12: pre_tick = tick12;
            qctu_pkg::QCTU_SCALE_DIV4: pre_tick = tick4;
            qctu_pkg::QCTU_SCALE_DIV48: pre_tick = tick48;
            default: pre_tick = ext_tick;
        endcase
    end

    // per-timer advance: event edge or chosen clock
    assign tk0 = timer0_counter_sel ? ev0_fall : (timer0_clock_pick ? 1'b1 : pre_tick);
    assign tk1 = timer1_counter_sel ? ev1_fall : (timer1_clock_pick ? 1'b1 : pre_tick);
    assign tk0h = timer0_clock_pick ? 1'b1 : pre_tick;
    assign ov0 = timer0_run && tk0 && ov_hit(timer0_mode, th0_ff, tl0_ff);
    assign ov1 = timer1_run && tk1 && (timer1_mode != qctu_pkg::QCTU_MODE_SPLIT)
        && ov_hit(timer1_mode, th1_ff, tl1_ff);
    assign ov0h = (timer0_mode == qctu_pkg::QCTU_MODE_SPLIT) && timer1_run && tk0h
        && (th0_ff == 8'hFF);

    // timer 0 counts; split mode borrows timer 1 run for the high byte
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tl0_ff <= `QCTU_COUNT_RESET;
            th0_ff <= `QCTU_COUNT_RESET;
        end else begin
            if (timer0_run && tk0) begin
                case (timer0_mode)
                    qctu_pkg::QCTU_MODE_13BIT: begin
                        tl0_ff[4:0] <= tl0_ff[4:0] + 5'h01;
                        if (tl0_ff[4:0] == 5'h1F) begin
                            th0_ff <= th0_ff + 8'h01;
                        end
                    end
                    qctu_pkg::QCTU_MODE_16BIT: {th0_ff, tl0_ff} <= {th0_ff, tl0_ff} + 16'h0001;
                    qctu_pkg::QCTU_MODE_8BIT_RELOAD: begin
                        tl0_ff <= (tl0_ff == 8'hFF) ? th0_ff : tl0_ff + 8'h01;
                    end
                    default: tl0_ff <= tl0_ff + 8'h01;
                endcase
            end
            if (timer0_mode == qctu_pkg::QCTU_MODE_SPLIT && timer1_run && tk0h) begin
                th0_ff <= th0_ff + 8'h01;
            end
        end
    end

    // timer 1 counts; holds in split mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tl1_ff <= `QCTU_COUNT_RESET;
            th1_ff <= `QCTU_COUNT_RESET;
        end else if (timer1_run && tk1) begin
            case (timer1_mode)
                qctu_pkg::QCTU_MODE_13BIT: begin
                    tl1_ff[4:0] <= tl1_ff[4:0] + 5'h01;
                    if (tl1_ff[4:0] == 5'h1F) begin
                        th1_ff <= th1_ff + 8'h01;
                    end
                end
                qctu_pkg::QCTU_MODE_16BIT: {th1_ff, tl1_ff} <= {th1_ff, tl1_ff} + 16'h0001;
                qctu_pkg::QCTU_MODE_8BIT_RELOAD: begin
                    tl1_ff <= (tl1_ff == 8'hFF) ? th1_ff : tl1_ff + 8'h01;
                end
                default: tl1_ff <= tl1_ff;
            endcase
        end
    end

    // timer 0/1 flags: set beats software clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tf0_ff <= 1'b0;
            tf1_ff <= 1'b0;
        end else begin
            tf0_ff <= ov0 ? 1'b1 : (timer0_flag_clr ? 1'b0 : tf0_ff);
            tf1_ff <= (ov1 || ov0h) ? 1'b1 : (timer1_flag_clr ? 1'b0 : tf1_ff);
        end
    end

    assign timer0_count_low = tl0_ff;
    assign timer0_count_high = th0_ff;
    assign timer1_count_low = tl1_ff;
    assign timer1_count_high = th1_ff;
    assign timer0_flag = tf0_ff;
    assign timer1_flag = tf1_ff;

    // timer 2 mirrors timer 3 with its own reload bytes
    qctu_reload_timer u_timer2 (
        .clk(clk),
        .nrst(nrst),
        .split(timer2_split_select),
        .run(timer2_run),
        .low_clock_pick(timer2_low_clock_pick),
        .high_clock_pick(timer2_high_clock_pick),
        .alt_tick(timer2_ext_clock_select ? ext_tick : tick12),
        .reload_low(t2_reload_low_ff),
        .reload_high(t2_reload_high_ff),
        .irq_enable(timer2_irq_enable),
        .low_irq_enable(timer2_low_irq_enable),
        .clr_high_flag(timer2_high_flag_clr),
        .clr_low_flag(timer2_low_flag_clr),
        .count_low(timer2_count_low),
        .count_high(timer2_count_high),
        .high_flag(timer23_flags[0]),
        .low_flag(timer23_flags[1]),
        .irq(timer2_irq)
    );

    // timer 3: split and low irq enable from its control byte
    qctu_reload_timer u_timer3 (
        .clk(clk),
        .nrst(nrst),
        .split(timer3_control[`QCTU_CTRL_SPLIT_BIT]),
        .run(timer3_control[`QCTU_CTRL_RUN_BIT]),
        .low_clock_pick(timer3_low_clock_pick),
        .high_clock_pick(timer3_high_clock_pick),
        .alt_tick(timer3_ext_clock_select ? ext_tick : tick12),
        .reload_low(timer3_reload_low),
        .reload_high(timer3_reload_high),
        .irq_enable(timer3_irq_enable),
        .low_irq_enable(timer3_control[`QCTU_CTRL_LOW_IRQ_EN_BIT]),
        .clr_high_flag(timer3_high_flag_clr),
        .clr_low_flag(timer3_low_flag_clr),
        .count_low(timer3_count_low),
        .count_high(timer3_count_high),
        .high_flag(timer23_flags[2]),
        .low_flag(timer23_flags[3]),
        .irq(timer3_irq)
    );

    property p_t2_write;
        @(posedge clk) disable iff (!nrst)
        sfr_wr && sfr_addr == `QCTU_ADDR_T2_RELOAD_LOW |=> t2_reload_low_ff == $past(sfr_wdata);
    endproperty
    a_t2_write: assert property (p_t2_write) else $error("reload low not written");
    property p_event_count;
        @(posedge clk) disable iff (!nrst)
        timer0_counter_sel && timer0_run && ev0_fall
            && timer0_mode == qctu_pkg::QCTU_MODE_16BIT && tl0_ff != 8'hFF
            |=> tl0_ff == $past(tl0_ff) + 8'h01;
    endproperty
    a_event_count: assert property (p_event_count) else $error("event not counted");
    property p_no_event_hold;
        @(posedge clk) disable iff (!nrst)
        timer0_counter_sel && !ev0_fall && timer0_mode == qctu_pkg::QCTU_MODE_16BIT
            |=> tl0_ff == $past(tl0_ff);
    endproperty
    a_no_event_hold: assert property (p_no_event_hold) else $error("counted w/o edge");
    property p_t1_split_hold;
        @(posedge clk) disable iff (!nrst)
        timer1_mode == qctu_pkg::QCTU_MODE_SPLIT |=> tl1_ff == $past(tl1_ff);
    endproperty
    a_t1_split_hold: assert property (p_t1_split_hold) else $error("timer1 ran split");
    property p_div12;
        @(posedge clk) disable iff (!nrst)
        tick12 |=> !tick12 [*8] ##1 !tick12 ##1 !tick12 ##1 !tick12 ##1 tick12;
    endproperty
    a_div12: assert property (p_div12) else $error("divide by 12 wrong");
    property p_div4;
        @(posedge clk) disable iff (!nrst)
        scale == qctu_pkg::QCTU_SCALE_DIV4 && pre_tick |=> !tick4 [*3] ##1 tick4;
    endproperty
    a_div4: assert property (p_div4) else $error("divide by 4 wrong");
    c_event: cover property (@(posedge clk) ev0_fall && timer0_counter_sel && timer0_run);
    c_t0_flag: cover property (@(posedge clk) ov0);
    c_split_h: cover property (@(posedge clk) ov0h);
endmodule // qctu_top

// file: qctu_top_tb.sv
// self-checking bench for the quad counter/timer unit
module qctu_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // stimulus
    logic clk, nrst, sfr_wr, sfr_rd, ext_osc_div8, timer0_event_pin, timer1_event_pin;
    logic [7:0] sfr_addr, sfr_wdata, timer3_control, timer3_reload_low, timer3_reload_high;
    logic timer0_run, timer1_run, timer0_counter_sel, timer1_counter_sel;
    logic timer0_clock_pick, timer1_clock_pick, prescale_field_hi, prescale_field_lo;
    logic timer0_flag_clr, timer1_flag_clr, timer2_split_select, timer2_run;
    logic timer2_ext_clock_select, timer2_low_clock_pick, timer2_high_clock_pick;
    logic timer2_irq_enable, timer2_low_irq_enable, timer2_high_flag_clr, timer2_low_flag_clr;
    logic timer3_ext_clock_select, timer3_low_clock_pick, timer3_high_clock_pick;
    logic timer3_irq_enable, timer3_high_flag_clr, timer3_low_flag_clr;
    qctu_pkg::qctu_mode_t timer0_mode, timer1_mode;
    // observed state
    logic [7:0] sfr_rdata, timer0_count_low, timer0_count_high, timer1_count_low;
    logic [7:0] timer1_count_high, timer2_count_low, timer2_count_high;
    logic [7:0] timer3_count_low, timer3_count_high;
    logic timer0_flag, timer1_flag, timer2_irq, timer3_irq;
    logic [3:0] timer23_flags;
    // reference model state
    logic [15:0] m2, a, b;
    logic [7:0] m3l, m3h, rl2l, rl2h, r, e;
    logic [3:0] mf;
    bit t3on;
    int errors, checked, k;
    int per_c[5] = '{240, 80, 480, 160, 50};
    int exp_c[5] = '{20, 20, 10, 20, 50};

    qctu_top i_qctu_top (.*);

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // outside oscillator divided by eight: one rise per eight cycles
    initial begin
        ext_osc_div8 = 1'b0;
        forever begin
            repeat (4) @(posedge clk);
            #1 ext_osc_div8 = ~ext_osc_div8;
        end
    end
    // cycle model of timers 2 and 3, system clock picked
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {m2, m3l, m3h, mf, rl2l, rl2h} = '0;
        end else begin
            // clear first so a same-cycle set wins
            mf = mf & ~{timer3_low_flag_clr, timer3_high_flag_clr,
                        timer2_low_flag_clr, timer2_high_flag_clr};
            if (timer2_run) begin
                if (m2[7:0] == 8'hFF) mf[1] = 1'b1;
                if (m2 == 16'hFFFF) begin
                    m2 = {rl2h, rl2l};
                    mf[0] = 1'b1;
                end else m2 = m2 + 16'h0001;
            end
            // split halves, low one free-running
            if (m3l == 8'hFF) begin
                m3l = timer3_reload_low;
                mf[3] = 1'b1;
            end else m3l = m3l + 8'h01;
            if (timer3_control[2]) begin
                if (m3h == 8'hFF) begin
                    m3h = timer3_reload_high;
                    mf[2] = 1'b1;
                end else m3h = m3h + 8'h01;
            end
            if (sfr_wr && sfr_addr == 8'hCA) rl2l = sfr_wdata;
            if (sfr_wr && sfr_addr == 8'hCB) rl2h = sfr_wdata;
        end
    end
    // compare with the model every cycle
    always @(negedge clk) begin
        if (nrst) begin
            check({timer2_count_high, timer2_count_low, timer23_flags[1:0], timer2_irq},
                {m2, mf[1:0], timer2_irq_enable & (mf[0] | timer2_low_irq_enable & mf[1])});
            if (t3on) check({timer3_count_high, timer3_count_low, timer23_flags[3:2], timer3_irq},
                {m3h, m3l, mf[3:2], timer3_irq_enable & (mf[2] | timer3_control[5] & mf[3])});
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask
    // let n edges pass, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        sfr_addr = ad;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] x);
        sfr_addr = ad;
        sfr_rd = 1'b1;
        tick(1);
        sfr_rd = 1'b0;
        check(sfr_rdata, x);
        tick(1);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // hang guard, well past the expected run
    initial begin
        #1800000;
        errors++;
        complete_run;
    end

    initial begin
        {nrst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, timer3_reload_low, timer3_reload_high} = '0;
        {timer1_counter_sel, timer0_flag_clr, timer1_flag_clr, prescale_field_hi} = '0;
        {prescale_field_lo, timer0_clock_pick, timer1_clock_pick, timer2_split_select} = '0;
        {timer2_ext_clock_select, timer2_irq_enable, timer2_low_irq_enable} = '0;
        {timer2_high_flag_clr, timer2_low_flag_clr, timer3_ext_clock_select} = '0;
        {timer3_irq_enable, timer3_high_flag_clr, timer3_low_flag_clr} = '0;
        {timer0_event_pin, timer1_event_pin, timer0_run, timer1_run, timer0_counter_sel} = '1;
        {timer2_run, timer2_low_clock_pick, timer2_high_clock_pick} = '1;
        {timer3_low_clock_pick, timer3_high_clock_pick, t3on} = '1;
        timer3_control = 8'h08;
        timer0_mode = qctu_pkg::QCTU_MODE_16BIT;
        timer1_mode = qctu_pkg::QCTU_MODE_16BIT;
        void'($urandom(31));
        tick(4);
        nrst = 1'b1;
        // reload registers: reset, readback, unmapped place
        rd(8'hCA, 8'h00);
        rd(8'hCB, 8'h00);
        r = $urandom;
        wr(8'hCA, r);
        wr(8'hCB, ~r);
        wr(8'hC9, 8'h5A);
        rd(8'hCA, r);
        rd(8'hCB, ~r);
        rd(8'hC9, 8'h00);
        wr(8'hCB, 8'hFF);
        wr(8'hCA, $urandom);
        $display("test registers done");
        // timer 1 through every clock source
        for (k = 0; k < 5; k++) begin
            {prescale_field_hi, prescale_field_lo} = k[1:0];
            timer1_clock_pick = (k == 4);
            tick(100);
            a = {timer1_count_high, timer1_count_low};
            tick(per_c[k]);
            b = {timer1_count_high, timer1_count_low} - a;
            check(b, exp_c[k]);
        end
        $display("test clock sources done");
        // timer 0 counting falling pin edges, levels held two to four cycles
        a = {timer0_count_high, timer0_count_low};
        for (k = 0; k < 12; k++) begin
            timer0_event_pin = 1'b0;
            tick($urandom_range(4, 2));
            timer0_event_pin = 1'b1;
            tick($urandom_range(4, 2));
        end
        tick(5);
        b = {timer0_count_high, timer0_count_low} - a;
        check(b, 12);
        $display("test event counting done");
        // random run, enables and clears against the model
        repeat (2000) begin
            {timer3_control[5], timer3_control[2], timer3_irq_enable, timer2_irq_enable,
             timer2_low_irq_enable, timer2_ext_clock_select, timer1_event_pin} = $urandom;
            {timer3_reload_high, timer3_reload_low} = $urandom;
            timer0_mode = qctu_pkg::qctu_mode_t'(2'($urandom));
            timer1_mode = qctu_pkg::qctu_mode_t'(2'($urandom));
            {timer3_low_flag_clr, timer3_high_flag_clr, timer2_low_flag_clr,
             timer2_high_flag_clr, timer0_flag_clr, timer1_flag_clr} =
                ($urandom_range(7) == 0) ? $urandom : 0;
            tick(1);
        end
        {timer3_low_flag_clr, timer3_high_flag_clr, timer2_low_flag_clr} = '0;
        {timer2_high_flag_clr, timer0_flag_clr, timer1_flag_clr} = '0;
        timer1_mode = qctu_pkg::QCTU_MODE_13BIT;
        $display("test random split done");
        // timer 3 low half on the slow clocks, model set aside
        t3on = 1'b0;
        {timer3_low_clock_pick, timer3_reload_low, timer3_ext_clock_select} = '0;
        for (k = 0; k < 2; k++) begin
            timer3_ext_clock_select = k[0];
            tick(50);
            r = timer3_count_low;
            tick(k ? 160 : 240);
            e = timer3_count_low - r;
            check(e, 20);
        end
        $display("test slow clocks done");
        // timer 2 runs on until its 16-bit wrap and reloads
        tick(66000);
        check(timer1_flag, 1'b1);
        $display("test sixteen bit wrap done");
        complete_run;
    end
endmodule // qctu_top_tb
